// ==== hrap_params.svh ====
`ifndef HRAP_PARAMS_SVH
`define HRAP_PARAMS_SVH
// Address space and register offsets.
`define HRAP_ADDR_W         7
`define HRAP_OFS_POLARITY   7'h0c
`define HRAP_OFS_PERIOD_LO  7'h0d
`define HRAP_OFS_PERIOD_HI  7'h0e
`define HRAP_OFS_DEAD       7'h0f
`define HRAP_OFS_ISCL_LO    7'h15
`define HRAP_OFS_ISCL_HI    7'h16
`define HRAP_OFS_RUN        7'h17
`define HRAP_OFS_MSCL_LO    7'h44
`define HRAP_OFS_MSCL_HI    7'h45
`define HRAP_OFS_GUARD      7'h51
`define HRAP_OFS_RECAL      7'h7d
// Storage slots, one per implemented register.
`define HRAP_NUM_SLOTS      11
`define HRAP_SLOT_POLARITY  0
`define HRAP_SLOT_PERIOD_LO 1
`define HRAP_SLOT_PERIOD_HI 2
`define HRAP_SLOT_DEAD      3
`define HRAP_SLOT_ISCL_LO   4
`define HRAP_SLOT_ISCL_HI   5
`define HRAP_SLOT_RUN       6
`define HRAP_SLOT_MSCL_LO   7
`define HRAP_SLOT_MSCL_HI   8
`define HRAP_SLOT_GUARD     9
`define HRAP_SLOT_RECAL     10
`define HRAP_REG_RST        8'h00
// Field positions.
`define HRAP_POL_SHUTDOWN   7
`define HRAP_POL_LOW_GATE   5
`define HRAP_POL_HIGH_GATE  4
`define HRAP_POL_CARRIER    3
`define HRAP_POL_CHOPPER    2
`define HRAP_POL_DRV_SD     1
`define HRAP_HI_DUAL_EN     7
`define HRAP_HI_VARIANT     6
`define HRAP_HI_CENTRE      4
`define HRAP_RUN_DIR        0
`define HRAP_RUN_CMD        1
`define HRAP_RUN_ESTOP      2
`define HRAP_CMD_READ_BIT   7
`define HRAP_ACK_ERR_BIT    7
`define HRAP_MAX_WR_BYTES   6
// Timing.
`define HRAP_CLK_HZ         250000000
`define HRAP_BAUD           57600
`define HRAP_BIT_CYCLES     (`HRAP_CLK_HZ / `HRAP_BAUD)
`define HRAP_TIMEOUT_MS     32
`define HRAP_TIMEOUT_CYCLES (`HRAP_TIMEOUT_MS * (`HRAP_CLK_HZ / 1000))
`endif

// ==== hrap_pkg.sv ====
package hrap_pkg;
  typedef enum logic [7:0] {
    HRAP_IDLE  = 8'h01,
    HRAP_CNT   = 8'h02,
    HRAP_DATA  = 8'h04,
    HRAP_SUM   = 8'h08,
    HRAP_WR    = 8'h10,
    HRAP_ACK   = 8'h20,
    HRAP_RDATA = 8'h40,
    HRAP_TSUM  = 8'h80
  } hrap_rs_state_e;
endpackage : hrap_pkg

// ==== hrap_top.sv ====
`timescale 1ns/1ps
`include "hrap_params.svh"
// Behaviour
// - One 128-location byte address space decoded for all host ports.
// - Parallel write with pointer select high loads the pointer.
// - Pointer advances by one after every parallel data byte.
// - Pointer load accepted any time; sequential access restarts there.
// - SPI command byte: bit 7 read-only flag, bits 6..0 start location.
// - SPI accesses start location first, then increments per byte until deselect.
// - Serial command bit 7 selects read, bits 6..0 start location.
// - Every serial frame ends with eight-bit sum of preceding bytes.
// - Serial write: check sum, write consecutive locations, send ack and sum.
// - Ack byte holds start location, bit 7 set on error.
// - Serial read request is command, count, checksum; sum checked first.
// - Read reply: ack, data, sum; failed read: error ack and sum.
// - Incomplete incoming serial frame abandoned 32 ms after it began.
// - Polarity register bits select sense of gate and pulse signals.
// - Run control: bit 0 direction, bit 1 run, bit 2 emergency coast.
// - Carrier period is two times value plus one clock periods.
// - Centre alignment, dual-leg enable and variant bits select PWM mode.
// - Dead interval register counts system clock cycles.
// - Guard band applies only in three-phase modulation.
module hrap_top #(
  parameter int BIT_CYCLES     = `HRAP_BIT_CYCLES,
  parameter int TIMEOUT_CYCLES = `HRAP_TIMEOUT_CYCLES
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_host_cs_n,
  input  wire logic        i_host_oe_n,
  input  wire logic        i_host_we_n,
  input  wire logic        i_host_pointer_select,
  input  wire logic [7:0]  i_host_parallel_bus,
  output logic      [7:0]  o_host_parallel_bus,
  output logic             o_host_parallel_bus_oe_n,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  output logic             o_spi_miso_oe_n,
  input  wire logic        i_uart_rx,
  output logic             o_uart_tx,
  output logic             o_shutdown_input_polarity,
  output logic             o_low_side_gate_polarity,
  output logic             o_high_side_gate_polarity,
  output logic             o_carrier_pulse_polarity,
  output logic             o_chopper_polarity,
  output logic             o_driver_shutdown_out,
  output logic      [11:0] o_carrier_period_value,
  output logic      [13:0] o_carrier_period_cycles,
  output logic             o_centre_alignment_select,
  output logic             o_dual_leg_modulation_enable,
  output logic             o_dual_leg_variant,
  output logic      [7:0]  o_gate_dead_interval,
  output logic      [7:0]  o_sampling_guard_band,
  output logic      [15:0] o_current_scale,
  output logic      [15:0] o_modulator_scale,
  output logic      [7:0]  o_offset_recal_delay,
  output logic             o_rotation_forward,
  output logic             o_run_command,
  output logic             o_emergency_coast_request
);
  localparam logic [6:0] SLOT_OFS [`HRAP_NUM_SLOTS] = '{`HRAP_OFS_POLARITY, `HRAP_OFS_PERIOD_LO,
    `HRAP_OFS_PERIOD_HI, `HRAP_OFS_DEAD, `HRAP_OFS_ISCL_LO, `HRAP_OFS_ISCL_HI, `HRAP_OFS_RUN,
    `HRAP_OFS_MSCL_LO, `HRAP_OFS_MSCL_HI, `HRAP_OFS_GUARD, `HRAP_OFS_RECAL};

  logic [7:0] regs [`HRAP_NUM_SLOTS];

  // Maps a location to {hit, slot}; locations without a register miss.
  function automatic logic [4:0] slot_of(input logic [6:0] addr);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < `HRAP_NUM_SLOTS; i++) begin
      if (SLOT_OFS[i] == addr) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : slot_of

  // Read data for any port; unimplemented locations return zero.
  function automatic logic [7:0] rd_byte(input logic [6:0] addr);
    logic [4:0] s;
    s = slot_of(addr);
    return s[4] ? regs[s[3:0]] : 8'h00;
  endfunction : rd_byte

  // Registered write requests from the three ports.
  logic       p_we, s_we, u_we;
  logic [6:0] p_waddr, s_waddr, u_waddr;
  logic [7:0] p_wdata, s_wdata, u_wdata;
  wire        w_en   = p_we | s_we | u_we;
  wire  [6:0] w_addr = p_we ? p_waddr : (s_we ? s_waddr : u_waddr);
  wire  [7:0] w_data = p_we ? p_wdata : (s_we ? s_wdata : u_wdata);
  wire  [4:0] w_slot = slot_of(w_addr);

  // One storage byte per implemented register; other writes fall away.
  genvar g;
  generate
    for (g = 0; g < `HRAP_NUM_SLOTS; g++) begin : g_reg
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          regs[g] <= `HRAP_REG_RST;
        end else if (w_en && w_slot[4] && w_slot[3:0] == 4'(g)) begin
          regs[g] <= w_data;
        end
      end
    end
  endgenerate

  // Register fields driven straight from storage.
  assign o_shutdown_input_polarity = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_SHUTDOWN];
  assign o_low_side_gate_polarity  = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_LOW_GATE];
  assign o_high_side_gate_polarity = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_HIGH_GATE];
  assign o_carrier_pulse_polarity  = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_CARRIER];
  assign o_chopper_polarity        = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_CHOPPER];
  assign o_driver_shutdown_out     = regs[`HRAP_SLOT_POLARITY][`HRAP_POL_DRV_SD];
  assign o_carrier_period_value    = {regs[`HRAP_SLOT_PERIOD_HI][3:0],
                                      regs[`HRAP_SLOT_PERIOD_LO]};
  assign o_centre_alignment_select = regs[`HRAP_SLOT_PERIOD_HI][`HRAP_HI_CENTRE];
  assign o_dual_leg_modulation_enable = regs[`HRAP_SLOT_PERIOD_HI][`HRAP_HI_DUAL_EN];
  assign o_dual_leg_variant        = regs[`HRAP_SLOT_PERIOD_HI][`HRAP_HI_VARIANT];
  assign o_gate_dead_interval      = regs[`HRAP_SLOT_DEAD];
  assign o_current_scale           = {regs[`HRAP_SLOT_ISCL_HI], regs[`HRAP_SLOT_ISCL_LO]};
  assign o_modulator_scale         = {regs[`HRAP_SLOT_MSCL_HI], regs[`HRAP_SLOT_MSCL_LO]};
  assign o_offset_recal_delay      = regs[`HRAP_SLOT_RECAL];
  assign o_rotation_forward        = regs[`HRAP_SLOT_RUN][`HRAP_RUN_DIR];
  assign o_run_command             = regs[`HRAP_SLOT_RUN][`HRAP_RUN_CMD];
  assign o_emergency_coast_request = regs[`HRAP_SLOT_RUN][`HRAP_RUN_ESTOP];

  // Carrier length in clocks and guard band masked off in dual-leg mode.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_carrier_period_cycles <= 14'h0000;
      o_sampling_guard_band   <= 8'h00;
    end else begin
      o_carrier_period_cycles <= {1'b0, o_carrier_period_value, 1'b0} + 14'h0002;
      o_sampling_guard_band   <= o_dual_leg_modulation_enable ? 8'h00
                                 : regs[`HRAP_SLOT_GUARD];
    end
  end

  // Parallel port: two-stage synchronisers on every pin.
  logic [11:0] p_m, p_s;
  logic        p_cs_q, p_a_q, p_we_q, p_oe_q;
  logic [7:0]  p_d_q;
  logic [6:0]  p_ptr;
  wire  [4:0]  p_slot = slot_of(p_ptr);
  wire         p_cs_n = p_s[11];
  wire         p_rise = p_cs_n & ~p_cs_q;
  wire         p_drive = ~p_cs_n & ~p_s[10] & p_s[9] & ~p_s[8];
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      p_m <= 12'hfff;
      p_s <= 12'hfff;
    end else begin
      p_m <= {i_host_cs_n, i_host_oe_n, i_host_we_n, i_host_pointer_select, i_host_parallel_bus};
      p_s <= p_m;
    end
  end

  // Strobe values are held while selected and acted on at deselect.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      p_cs_q <= 1'b1;
      {p_oe_q, p_we_q, p_a_q, p_d_q} <= 11'h600;
      p_ptr <= 7'h00;
      p_we  <= 1'b0;
      p_waddr <= 7'h00;
      p_wdata <= 8'h00;
      o_host_parallel_bus <= 8'h00;
      o_host_parallel_bus_oe_n <= 1'b1;
    end else begin
      p_cs_q <= p_cs_n;
      p_we   <= 1'b0;
      if (!p_cs_n) begin
        {p_oe_q, p_we_q, p_a_q, p_d_q} <= p_s[10:0];
      end
      if (p_rise && !p_we_q && p_a_q) begin
        p_ptr <= p_d_q[6:0];
      end else if (p_rise && !p_a_q && (!p_we_q || !p_oe_q)) begin
        p_we    <= ~p_we_q;
        p_waddr <= p_ptr;
        p_wdata <= p_d_q;
        p_ptr   <= p_ptr + 7'h01;
      end
      o_host_parallel_bus <= rd_byte(p_ptr);
      o_host_parallel_bus_oe_n <= ~p_drive;
    end
  end

  // SPI port, mode 0: sample on rising clock, shift out on falling clock.
  logic [2:0] s_m, s_s;
  logic       s_clk_q, s_cmd, s_ro;
  logic [2:0] s_bits;
  logic [6:0] s_sh, s_ptr;
  logic [7:0] s_tx;
  wire        s_rise = s_s[1] & ~s_clk_q;
  wire        s_fall = ~s_s[1] & s_clk_q;
  wire  [7:0] s_byte = {s_sh, s_s[0]};
  wire        s_done = s_rise && s_bits == 3'h7;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_m <= 3'h4;
      s_s <= 3'h4;
    end else begin
      s_m <= {i_spi_cs_n, i_spi_sclk, i_spi_mosi};
      s_s <= s_m;
    end
  end

  // Command byte sets flag and pointer; data bytes advance the pointer.
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s_clk_q <= 1'b0;
      {s_cmd, s_ro, s_bits, s_sh, s_ptr, s_tx} <= 27'h4000000;
      {s_we, s_waddr, s_wdata} <= 16'h0000;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe_n <= 1'b1;
    end else begin
      s_clk_q <= s_s[1];
      s_we    <= 1'b0;
      o_spi_miso_oe_n <= s_s[2];
      if (s_s[2]) begin
        s_cmd  <= 1'b1;
        s_bits <= 3'h0;
        s_tx   <= 8'h00;
      end else if (s_rise) begin
        s_sh   <= s_byte[6:0];
        s_bits <= s_bits + 3'h1;
        if (s_done && s_cmd) begin
          s_cmd <= 1'b0;
          s_ro  <= s_byte[7];
          s_ptr <= s_byte[6:0];
          s_tx  <= rd_byte(s_byte[6:0]);
        end else if (s_done) begin
          s_we    <= ~s_ro;
          s_waddr <= s_ptr;
          s_wdata <= s_byte;
          s_ptr   <= s_ptr + 7'h01;
          s_tx    <= rd_byte(s_ptr + 7'h01);
        end
      end else if (s_fall) begin
        o_spi_miso <= s_tx[7];
        s_tx <= {s_tx[6:0], 1'b0};
      end
    end
  end

  // Serial receiver, 8N1, sampled mid-bit.
  logic        rx_m, rx_s, rx_busy, rx_done;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [7:0]  rx_sh;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {rx_m, rx_s} <= 2'h3;
      {rx_busy, rx_done, rx_cnt, rx_idx, rx_sh} <= 30'h00000000;
    end else begin
      {rx_m, rx_s} <= {i_uart_rx, rx_m};
      rx_done <= 1'b0;
      if (!rx_busy) begin
        rx_busy <= ~rx_s;
        rx_cnt  <= 16'(BIT_CYCLES / 2);
        rx_idx  <= 4'h0;
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= 16'(BIT_CYCLES - 1);
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == 4'h0 && rx_s) begin
          rx_busy <= 1'b0;
        end else if (rx_idx == 4'h9) begin
          rx_busy <= 1'b0;
          rx_done <= rx_s;
        end else if (rx_idx != 4'h0) begin
          rx_sh <= {rx_s, rx_sh[7:1]};
        end
      end
    end
  end

  // Serial transmitter, 8N1; the line idles high.
  logic        tx_go, tx_busy;
  logic [7:0]  tx_byte;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_idx;
  logic [9:0]  tx_sh;
  wire         tx_ready = ~tx_busy & ~tx_go;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      {tx_busy, tx_cnt, tx_idx} <= 21'h000000;
      tx_sh <= 10'h3ff;
      o_uart_tx <= 1'b1;
    end else begin
      o_uart_tx <= tx_sh[0];
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh   <= {1'b1, tx_byte, 1'b0};
        tx_cnt  <= 16'(BIT_CYCLES - 1);
        tx_idx  <= 4'h0;
      end else if (tx_busy && tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_busy) begin
        tx_cnt  <= 16'(BIT_CYCLES - 1);
        tx_sh   <= {1'b1, tx_sh[9:1]};
        tx_idx  <= tx_idx + 4'h1;
        tx_busy <= tx_idx != 4'h9;
      end
    end
  end

  // Serial frame engine: receive, check, commit, reply.
  hrap_pkg::hrap_rs_state_e st;
  logic [7:0]  u_cmd, u_cnt, u_sum, u_idx;
  logic        u_err;
  logic [23:0] u_tmo;
  logic [7:0]  u_buf [`HRAP_MAX_WR_BYTES];
  wire         u_read  = u_cmd[`HRAP_CMD_READ_BIT];
  wire         u_badcnt = u_read ? u_cnt == 8'h00
                          : (u_cnt == 8'h00 || u_cnt > 8'(`HRAP_MAX_WR_BYTES));
  wire         u_rxing = st == hrap_pkg::HRAP_CNT || st == hrap_pkg::HRAP_DATA
                         || st == hrap_pkg::HRAP_SUM;
  wire         u_tmo_hit = u_rxing && u_tmo == 24'(TIMEOUT_CYCLES - 1);
  wire         u_sum_bad = rx_sh != u_sum;
  wire  [7:0]  u_ack = {u_err, u_cmd[6:0]};
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st <= hrap_pkg::HRAP_IDLE;
      {u_cmd, u_cnt, u_sum, u_idx, u_err, u_tmo} <= 57'h0;
      {tx_go, tx_byte} <= 9'h000;
      {u_we, u_waddr, u_wdata} <= 16'h0000;
      for (int i = 0; i < `HRAP_MAX_WR_BYTES; i++) begin
        u_buf[i] <= 8'h00;
      end
    end else begin
      tx_go <= 1'b0;
      u_we  <= 1'b0;
      u_tmo <= u_rxing ? u_tmo + 24'h000001 : 24'h000000;
      if (u_tmo_hit) begin
        st <= hrap_pkg::HRAP_IDLE;
      end else begin
        case (st)
          hrap_pkg::HRAP_IDLE: begin
            if (rx_done) begin
              u_cmd <= rx_sh;
              u_sum <= rx_sh;
              st    <= hrap_pkg::HRAP_CNT;
            end
          end
          hrap_pkg::HRAP_CNT: begin
            if (rx_done) begin
              u_cnt <= rx_sh;
              u_sum <= u_sum + rx_sh;
              u_idx <= 8'h00;
              st    <= (u_read || rx_sh == 8'h00) ? hrap_pkg::HRAP_SUM : hrap_pkg::HRAP_DATA;
            end
          end
          hrap_pkg::HRAP_DATA: begin
            if (rx_done) begin
              if (u_idx < 8'(`HRAP_MAX_WR_BYTES)) begin
                u_buf[u_idx[2:0]] <= rx_sh;
              end
              u_sum <= u_sum + rx_sh;
              u_idx <= u_idx + 8'h01;
              if (u_idx + 8'h01 == u_cnt) begin
                st <= hrap_pkg::HRAP_SUM;
              end
            end
          end
          hrap_pkg::HRAP_SUM: begin
            if (rx_done) begin
              u_err <= u_sum_bad | u_badcnt;
              u_idx <= 8'h00;
              st    <= (!u_sum_bad && !u_badcnt && !u_read) ? hrap_pkg::HRAP_WR
                       : hrap_pkg::HRAP_ACK;
            end
          end
          hrap_pkg::HRAP_WR: begin
            u_we    <= 1'b1;
            u_waddr <= u_cmd[6:0] + u_idx[6:0];
            u_wdata <= u_buf[u_idx[2:0]];
            u_idx   <= u_idx + 8'h01;
            if (u_idx + 8'h01 == u_cnt) begin
              st <= hrap_pkg::HRAP_ACK;
            end
          end
          hrap_pkg::HRAP_ACK: begin
            if (tx_ready) begin
              tx_go   <= 1'b1;
              tx_byte <= u_ack;
              u_sum   <= u_ack;
              u_idx   <= 8'h00;
              st      <= (u_read && !u_err) ? hrap_pkg::HRAP_RDATA : hrap_pkg::HRAP_TSUM;
            end
          end
          hrap_pkg::HRAP_RDATA: begin
            if (tx_ready) begin
              tx_go   <= 1'b1;
              tx_byte <= rd_byte(u_cmd[6:0] + u_idx[6:0]);
              u_sum   <= u_sum + rd_byte(u_cmd[6:0] + u_idx[6:0]);
              u_idx   <= u_idx + 8'h01;
              if (u_idx + 8'h01 == u_cnt) begin
                st <= hrap_pkg::HRAP_TSUM;
              end
            end
          end
          hrap_pkg::HRAP_TSUM: begin
            if (tx_ready) begin
              tx_go   <= 1'b1;
              tx_byte <= u_sum;
              st      <= hrap_pkg::HRAP_IDLE;
            end
          end
          default: st <= hrap_pkg::HRAP_IDLE;
        endcase
      end
    end
  end

  // Checks kept beside the logic.
  property p_unmapped_zero;
    @(posedge i_ref_clk) disable iff (i_srst)
      !p_slot[4] |=> o_host_parallel_bus == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_ptr_load;
    @(posedge i_ref_clk) disable iff (i_srst)
      (p_rise && !p_we_q && p_a_q) |=> p_ptr == $past(p_d_q[6:0]) && !p_we;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");
  property p_ptr_inc;
    @(posedge i_ref_clk) disable iff (i_srst)
      (p_rise && !p_a_q && !p_we_q) |=> p_ptr == $past(p_ptr) + 7'h01 && p_waddr == $past(p_ptr);
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
  property p_spi_cmd;
    @(posedge i_ref_clk) disable iff (i_srst)
      (!s_s[2] && s_done && s_cmd) |=> s_ptr == $past(s_byte[6:0]) && s_ro == $past(s_byte[7]);
  endproperty
  a_spi_cmd: assert property (p_spi_cmd) else $error("spi command decode wrong");
  property p_spi_ro;
    @(posedge i_ref_clk) disable iff (i_srst)
      (!s_s[2] && s_done && !s_cmd && s_ro) |=> !s_we ##1 !s_we;
  endproperty
  a_spi_ro: assert property (p_spi_ro) else $error("read-only spi wrote");
  property p_spi_inc;
    @(posedge i_ref_clk) disable iff (i_srst)
      (!s_s[2] && s_done && !s_cmd) |=> s_ptr == $past(s_ptr) + 7'h01;
  endproperty
  a_spi_inc: assert property (p_spi_inc) else $error("spi pointer not advanced");
  property p_timeout;
    @(posedge i_ref_clk) disable iff (i_srst)
      u_tmo_hit |=> st == hrap_pkg::HRAP_IDLE && !tx_go;
  endproperty
  a_timeout: assert property (p_timeout) else $error("frame timeout missed");
  property p_bad_sum;
    @(posedge i_ref_clk) disable iff (i_srst)
      (st == hrap_pkg::HRAP_SUM && rx_done && !u_tmo_hit && u_sum_bad)
        |=> st == hrap_pkg::HRAP_ACK && u_err ##1 !u_we;
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum not refused");
  property p_ack_bit;
    @(posedge i_ref_clk) disable iff (i_srst)
      (st == hrap_pkg::HRAP_ACK && tx_ready) |=> tx_go && tx_byte[7] == u_err
        && tx_byte[6:0] == u_cmd[6:0];
  endproperty
  a_ack_bit: assert property (p_ack_bit) else $error("ack byte wrong");
  property p_period;
    @(posedge i_ref_clk) disable iff (i_srst)
      $stable(o_carrier_period_value) |=>
        o_carrier_period_cycles == ({2'b00, $past(o_carrier_period_value)} + 14'h0001) * 14'h0002;
  endproperty
  a_period: assert property (p_period) else $error("carrier length wrong");
  property p_guard;
    @(posedge i_ref_clk) disable iff (i_srst)
      o_dual_leg_modulation_enable |=> o_sampling_guard_band == 8'h00;
  endproperty
  a_guard: assert property (p_guard) else $error("guard band not masked");
  c_par_write: cover property (@(posedge i_ref_clk) disable iff (i_srst) p_we ##[1:100] p_we);
  c_spi_data: cover property (@(posedge i_ref_clk) disable iff (i_srst) s_we);
  c_uart_wr: cover property (@(posedge i_ref_clk) disable iff (i_srst) u_we ##1 u_we);
  c_uart_rd: cover property (@(posedge i_ref_clk) disable iff (i_srst)
    st == hrap_pkg::HRAP_RDATA && tx_go);
endmodule : hrap_top

// ==== hrap_host_tx.sv ====
`timescale 1ns/1ps
// Host-side serial sender, 8N1 with the LSB first; the line rests high between bytes.
module hrap_host_tx #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_byte,
  output logic            o_tx,
  output logic            o_busy
);
  logic [9:0] sh_reg;
  int         cnt_reg = 0;
  // Loads a byte only when idle, so the host never overlaps two requests.
  always @(posedge i_ref_clk) begin
    if (i_go && cnt_reg == 0) begin
      sh_reg  <= {1'b1, i_byte, 1'b0};
      cnt_reg <= 10 * BIT_CYCLES;
    end else if (cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
      if (cnt_reg % BIT_CYCLES == 1) sh_reg <= {1'b1, sh_reg[9:1]};
    end
  end
  // The line shows the current bit while a byte is in flight.
  assign o_tx   = (cnt_reg > 0) ? sh_reg[0] : 1'b1;
  assign o_busy = cnt_reg > 0;
endmodule : hrap_host_tx

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        clk, srst, cs_n, oe_n, we_n, sel, go, rx, tx, fwd, run, estop;
  logic        scs, sclk, mosi, miso;
  wire  [5:0]  pol;
  wire  [2:0]  pm;
  logic [15:0] m, msc;
  logic [7:0]  pdat, gbyte, pout, dead, guard, r, b, s;
  logic [7:0]  d [4];
  logic [11:0] per;
  logic [13:0] cyc;
  int          seed = 16928;
  int          err_total = 0;
  int          num_checks = 0;
  int          i;
  hrap_host_tx #(.BIT_CYCLES(16)) u_host (.i_ref_clk(clk), .i_go(go), .i_byte(gbyte),
    .o_tx(rx), .o_busy());
  hrap_top #(.BIT_CYCLES(16), .TIMEOUT_CYCLES(20000)) u_dut (
    .i_ref_clk(clk), .i_srst(srst), .i_host_cs_n(cs_n), .i_host_oe_n(oe_n),
    .i_host_we_n(we_n), .i_host_pointer_select(sel), .i_host_parallel_bus(pdat),
    .o_host_parallel_bus(pout), .o_host_parallel_bus_oe_n(), .i_spi_cs_n(scs),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe_n(),
    .i_uart_rx(rx), .o_uart_tx(tx), .o_shutdown_input_polarity(pol[5]),
    .o_low_side_gate_polarity(pol[4]), .o_high_side_gate_polarity(pol[3]),
    .o_carrier_pulse_polarity(pol[2]), .o_chopper_polarity(pol[1]),
    .o_driver_shutdown_out(pol[0]), .o_carrier_period_value(per),
    .o_carrier_period_cycles(cyc), .o_centre_alignment_select(pm[0]),
    .o_dual_leg_modulation_enable(pm[2]), .o_dual_leg_variant(pm[1]),
    .o_gate_dead_interval(dead),
    .o_sampling_guard_band(guard), .o_current_scale(), .o_modulator_scale(msc),
    .o_offset_recal_delay(), .o_rotation_forward(fwd), .o_run_command(run),
    .o_emergency_coast_request(estop));
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // One parallel byte cycle; a read keeps the bus value in b.
  task automatic par(input logic a, input logic w, input logic [7:0] v);
    @(posedge clk);
    {cs_n, sel, we_n, oe_n, pdat} <= {1'b0, a, ~w, w, v};
    repeat (6) @(posedge clk);
    b = pout;
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : par
  // One SPI byte in mode 0, MSB first, 160 ns per bit; the MISO byte lands in b.
  task automatic spi(input logic [7:0] v);
    for (int k = 7; k >= 0; k--) begin
      mosi <= v[k];
      repeat (20) @(posedge clk);
      sclk <= 1'b1;
      b[k] = miso;
      repeat (20) @(posedge clk);
      sclk <= 1'b0;
    end
  endtask : spi
  // Carrier length in clocks for a given period value.
  function automatic logic [15:0] carrier_len(input logic [11:0] v);
    return 16'(2 * (v + 12'h001));
  endfunction : carrier_len
  // Sends one serial byte through the host model and waits out its frame.
  task automatic ub(input logic [7:0] v);
    @(posedge clk);
    {go, gbyte} <= {1'b1, v};
    @(posedge clk);
    go <= 1'b0;
    repeat (162) @(posedge clk);
  endtask : ub
  // Sends a frame and its sum; bad flips the low sum bit.
  task automatic frame(input logic [7:0] q [$], input logic bad);
    s = 8'h00;
    foreach (q[k]) begin
      ub(q[k]);
      s = s + q[k];
    end
    ub(s ^ {7'h00, bad});
  endtask : frame
  // Receives one reply byte at mid-bit points and compares it.
  task automatic urx(input logic [7:0] exp);
    for (i = 0; i < 3000 && tx !== 1'b0; i++) @(posedge clk);
    // A reply that never starts counts as a mismatch.
    if (tx !== 1'b0) begin
      err_total++;
    end
    repeat (8) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      b[i] = tx;
    end
    repeat (8) @(posedge clk);
    chk(b, exp);
  endtask : urx
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // Cuts a hang short well after the expected run length.
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  // Main sequence: parallel port, then SPI, then serial frames.
  initial begin
    {srst, cs_n, oe_n, we_n, sel, go, pdat, gbyte} = {4'hf, 2'b00, 16'h0000};
    {scs, sclk, mosi} = 3'b100;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(dead, 8'h00);
    for (i = 0; i < 4; i++) d[i] = 8'($random(seed));
    par(1'b1, 1'b1, 8'h0c);
    foreach (d[k]) par(1'b0, 1'b1, d[k]);
    chk(pol[5:1], {d[0][7], d[0][5:2]});
    chk(pol[0], d[0][1]);
    chk(per, {d[2][3:0], d[1]});
    chk(cyc, carrier_len({d[2][3:0], d[1]}));
    chk(pm, {d[2][7:6], d[2][4]});
    chk(dead, d[3]);
    par(1'b0, 1'b1, 8'h5a);
    par(1'b1, 1'b1, 8'h51);
    par(1'b0, 1'b1, 8'h3c);
    chk(guard, d[2][7] ? 8'h00 : 8'h3c);
    par(1'b1, 1'b1, 8'h0f);
    par(1'b0, 1'b0, 8'h00);
    chk(b, d[3]);
    par(1'b0, 1'b0, 8'h00);
    chk(b, 8'h00);
    $display("parallel test done");
    // SPI: write two bytes from 0x44, then read them back with the read-only flag.
    m = 16'($random(seed));
    @(posedge clk);
    scs <= 1'b0;
    spi(8'h44);
    spi(m[7:0]);
    chk(b, 8'h00);
    spi(m[15:8]);
    repeat (8) @(posedge clk);
    scs <= 1'b1;
    repeat (8) @(posedge clk);
    chk(msc, m);
    scs <= 1'b0;
    spi(8'hc4);
    spi(~m[7:0]);
    chk(b, m[7:0]);
    spi(~m[15:8]);
    chk(b, m[15:8]);
    repeat (8) @(posedge clk);
    scs <= 1'b1;
    repeat (8) @(posedge clk);
    chk(msc, m);
    $display("spi test done");
    r = 8'($random(seed)) & 8'h07;
    frame('{8'h17, 8'h01, r}, 1'b0);
    urx(8'h17);
    urx(8'h17);
    chk({fwd, run, estop}, {r[0], r[1], r[2]});
    frame('{8'h17, 8'h01, ~r}, 1'b1);
    urx(8'h97);
    urx(8'h97);
    chk({fwd, run, estop}, {r[0], r[1], r[2]});
    ub(8'h17);
    repeat (20100) @(posedge clk);
    frame('{8'h8e, 8'h02}, 1'b0);
    urx(8'h0e);
    urx(d[2]);
    urx(d[3]);
    urx(8'h0e + d[2] + d[3]);
    $display("serial test done");
    end_sim();
  end
endmodule : tb_top
